/* rtl/lcoc_output_ctrl.sv */
`timescale 1ns/100ps
// How it works
// - Latch mode keeps outputs off until reset.
// - Trip mode starts after self-test and clear beams.
// - Trip mode restarts itself once beams clear.
// - One switch input resets, tests and monitors.
// - Switch actuation while running starts a test.
// - Switch actuation in latch or lockout resets.
// - Any blocked beam turns both outputs off.
// - Two outputs carry periodic off-going test pulses.
module lcoc_output_ctrl #(
  parameter int unsigned PERIOD_CYC = lcoc_pkg::TEST_PERIOD_CYC,
  parameter int unsigned PULSE_CYC = lcoc_pkg::TEST_PULSE_CYC,
  parameter int unsigned DEBOUNCE_CYC = lcoc_pkg::SWITCH_DEBOUNCE_CYC,
  parameter int unsigned STUCK_CYC = lcoc_pkg::SWITCH_STUCK_CYC,
  parameter int unsigned TEST_CYC = lcoc_pkg::REMOTE_TEST_CYC
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Receiver status from on-chip logic
  input wire logic beams_clear_i,
  input wire logic self_test_ok_i,
  input wire logic internal_fault_i,
  // Pins: model strap and shared switch / monitor loop
  input wire logic latch_mode_i,
  input wire logic switch_loop_i,
  // Safety outputs to the machine control elements
  output logic safety_switch_output_a_o,
  output logic safety_switch_output_b_o,
  // Status
  output logic run_o,
  output logic lockout_o,
  output logic test_o
);

  localparam int unsigned W = lcoc_pkg::CNT_W;
  localparam logic [W-1:0] DEB_C = W'(DEBOUNCE_CYC);
  localparam logic [W-1:0] STUCK_C = W'(STUCK_CYC);
  localparam logic [W-1:0] TEST_C = W'(TEST_CYC - 1);

  // Pin synchronisers
  logic sw_meta_q;
  logic sw_sync_q;
  logic md_meta_q;
  logic md_sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_meta_q <= 1'b0;
      sw_sync_q <= 1'b0;
      md_meta_q <= lcoc_pkg::RST_LATCH_MODE;
      md_sync_q <= lcoc_pkg::RST_LATCH_MODE;
    end else if (ce_i) begin
      sw_meta_q <= switch_loop_i;
      sw_sync_q <= sw_meta_q;
      md_meta_q <= latch_mode_i;
      md_sync_q <= md_meta_q;
    end
  end

  // Switch loop: debounced closure then release is one actuation
  logic [W-1:0] press_q;
  logic [W-1:0] press_d;
  logic stuck_q;
  logic stuck_d;
  logic act;

  always_comb begin
    press_d = press_q;
    stuck_d = stuck_q;
    act = 1'b0;
    if (sw_sync_q) begin
      if (press_q < STUCK_C) begin
        press_d = press_q + 1'b1;
      end
      // A loop held closed means a welded contact or jammed switch
      stuck_d = stuck_q || (press_d >= STUCK_C);
    end else begin
      act = (press_q >= DEB_C) && (press_q < STUCK_C);
      press_d = '0;
      stuck_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      press_q <= '0;
      stuck_q <= 1'b0;
    end else if (ce_i) begin
      press_q <= press_d;
      stuck_q <= stuck_d;
    end
  end

  // Operating state machine
  lcoc_pkg::lcoc_state_e state_q;
  lcoc_pkg::lcoc_state_e state_d;
  logic mode_q;
  logic mode_d;
  logic [W-1:0] tcnt_q;
  logic [W-1:0] tcnt_d;
  logic fault;
  logic stopped;

  assign fault = internal_fault_i || stuck_q;

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    tcnt_d = '0;
    // Where a blocked beam leads depends on the model option
    stopped = 1'b0;
    case (state_q)
      lcoc_pkg::ST_POWERUP: begin
        mode_d = md_sync_q;
        if (self_test_ok_i && beams_clear_i) begin
          state_d = md_sync_q ? lcoc_pkg::ST_LATCH : lcoc_pkg::ST_RUN;
        end
      end
      lcoc_pkg::ST_LATCH: begin
        if (act && beams_clear_i) begin
          state_d = lcoc_pkg::ST_RUN;
        end
      end
      lcoc_pkg::ST_STOP: begin
        if (beams_clear_i) begin
          state_d = lcoc_pkg::ST_RUN;
        end
      end
      lcoc_pkg::ST_RUN: begin
        if (!beams_clear_i) begin
          stopped = 1'b1;
        end else if (act) begin
          state_d = lcoc_pkg::ST_TEST;
        end
      end
      lcoc_pkg::ST_TEST: begin
        tcnt_d = tcnt_q + 1'b1;
        if (tcnt_q >= TEST_C) begin
          if (beams_clear_i) begin
            state_d = lcoc_pkg::ST_RUN;
          end else begin
            stopped = 1'b1;
          end
        end
      end
      lcoc_pkg::ST_LOCKOUT: begin
        if (act && !internal_fault_i) begin
          state_d = lcoc_pkg::ST_POWERUP;
        end
      end
      default: begin
        state_d = lcoc_pkg::ST_LOCKOUT;
      end
    endcase
    if (stopped) begin
      state_d = mode_q ? lcoc_pkg::ST_LATCH : lcoc_pkg::ST_STOP;
    end
    if (fault) begin
      state_d = lcoc_pkg::ST_LOCKOUT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= lcoc_pkg::ST_POWERUP;
      mode_q <= lcoc_pkg::RST_LATCH_MODE;
      tcnt_q <= '0;
    end else if (ce_i) begin
      state_q <= state_d;
      mode_q <= mode_d;
      tcnt_q <= tcnt_d;
    end
  end

  // Test pulses run only while outputs are on
  logic pulse_a;
  logic pulse_b;

  lcoc_pulse_gen #(
    .PERIOD_CYC(PERIOD_CYC),
    .PULSE_CYC(PULSE_CYC)
  ) u_pulse (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(state_q == lcoc_pkg::ST_RUN),
    .pulse_a_o(pulse_a),
    .pulse_b_o(pulse_b)
  );

  // Output registers follow the next state so they line up with state_q
  logic out_a_q;
  logic out_b_q;
  logic run_q;
  logic lock_q;
  logic test_q;
  logic on_d;
  logic out_a_d;
  logic out_b_d;
  logic lock_d;
  logic test_d;

  // Next output levels; a test pulse drops only its own channel
  always_comb begin
    on_d = (state_d == lcoc_pkg::ST_RUN);
    out_a_d = on_d && !pulse_a;
    out_b_d = on_d && !pulse_b;
    lock_d = (state_d == lcoc_pkg::ST_LOCKOUT);
    test_d = (state_d == lcoc_pkg::ST_TEST);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_a_q <= lcoc_pkg::RST_OUT;
      out_b_q <= lcoc_pkg::RST_OUT;
      run_q <= 1'b0;
      lock_q <= 1'b0;
      test_q <= 1'b0;
    end else if (ce_i) begin
      out_a_q <= out_a_d;
      out_b_q <= out_b_d;
      run_q <= on_d;
      lock_q <= lock_d;
      test_q <= test_d;
    end
  end

  assign safety_switch_output_a_o = out_a_q;
  assign safety_switch_output_b_o = out_b_q;
  assign run_o = run_q;
  assign lockout_o = lock_q;
  assign test_o = test_q;

  // Checks
  a_latch_holds_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == lcoc_pkg::ST_LATCH) |-> !out_a_q && !out_b_q)
    else $error("outputs on while latched");
  a_auto_start: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == lcoc_pkg::ST_POWERUP) && ce_i && self_test_ok_i && beams_clear_i
    && !md_sync_q && !fault |=> run_q) else $error("trip start missed");
  a_auto_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == lcoc_pkg::ST_STOP) && ce_i && beams_clear_i && !fault
    |=> (state_q == lcoc_pkg::ST_RUN)) else $error("trip restart missed");
  a_run_test: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == lcoc_pkg::ST_RUN) && ce_i && act && beams_clear_i && !fault
    |=> test_q && !out_a_q && !out_b_q) else $error("test not started");
  a_latch_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == lcoc_pkg::ST_LATCH) && ce_i && act && beams_clear_i && !fault
    |=> run_q) else $error("latch reset ignored");
  a_lock_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == lcoc_pkg::ST_LOCKOUT) && ce_i && act && !fault
    |=> (state_q == lcoc_pkg::ST_POWERUP) && !lock_q) else $error("lockout reset ignored");
  a_block_stops: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !beams_clear_i |=> !out_a_q && !out_b_q) else $error("blocked beam left on");
  a_fault_locks: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && fault |=> lock_q && !out_a_q && !out_b_q) else $error("fault not locked out");
  a_pulse_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && pulse_a && on_d |=> !out_a_q && out_b_q) else $error("test pulse misplaced");

endmodule

/* rtl/lcoc_pkg.sv */
package lcoc_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1_000;

  // Off-going test pulse on the safety outputs
  localparam int unsigned TEST_PULSE_US = 200;
  localparam int unsigned TEST_PULSE_CYC = TEST_PULSE_US * CLK_PER_US;
  localparam int unsigned TEST_PERIOD_MS = 260;
  localparam int unsigned TEST_PERIOD_CYC = TEST_PERIOD_MS * CLK_PER_MS;

  // Shared switch input timing
  localparam int unsigned SWITCH_DEBOUNCE_MS = 20;
  localparam int unsigned SWITCH_DEBOUNCE_CYC = SWITCH_DEBOUNCE_MS * CLK_PER_MS;
  localparam int unsigned SWITCH_STUCK_MS = 3000;
  localparam int unsigned SWITCH_STUCK_CYC = SWITCH_STUCK_MS * CLK_PER_MS;

  // Length of the output-off window of a remote test
  localparam int unsigned REMOTE_TEST_MS = 50;
  localparam int unsigned REMOTE_TEST_CYC = REMOTE_TEST_MS * CLK_PER_MS;

  // Counter width for the switch and remote-test timers
  localparam int unsigned CNT_W = 28;

  // Reset values
  localparam logic RST_OUT = 1'b0;
  localparam logic RST_LATCH_MODE = 1'b1;

  // Operating states
  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_LATCH   = 3'b001,
    ST_STOP    = 3'b010,
    ST_RUN     = 3'b011,
    ST_TEST    = 3'b100,
    ST_LOCKOUT = 3'b101
  } lcoc_state_e;

endpackage

/* rtl/lcoc_pulse_gen.sv */
`timescale 1ns/100ps
module lcoc_pulse_gen #(
  parameter int unsigned PERIOD_CYC = lcoc_pkg::TEST_PERIOD_CYC,
  parameter int unsigned PULSE_CYC = lcoc_pkg::TEST_PULSE_CYC
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  // Test pulse requests, one per channel
  output logic pulse_a_o,
  output logic pulse_b_o
);

  localparam int unsigned W = $clog2(PERIOD_CYC);
  localparam logic [W-1:0] LAST = W'(PERIOD_CYC - 1);
  localparam logic [W-1:0] A_START = W'(PERIOD_CYC - PULSE_CYC);
  localparam logic [W-1:0] B_START = W'(PERIOD_CYC / 2 - PULSE_CYC);
  localparam logic [W-1:0] B_END = W'(PERIOD_CYC / 2);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic pa_q;
  logic pa_d;
  logic pb_q;
  logic pb_d;

  // Period counter; channels pulse half a period apart so one always conducts
  always_comb begin
    cnt_d = cnt_q;
    pa_d = 1'b0;
    pb_d = 1'b0;
    if (!run_i) begin
      cnt_d = '0;
    end else begin
      cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
      pa_d = (cnt_d >= A_START);
      pb_d = (cnt_d >= B_START) && (cnt_d < B_END);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      pa_q <= pa_d;
      pb_q <= pb_d;
    end
  end

  assign pulse_a_o = pa_q;
  assign pulse_b_o = pb_q;

  a_pulse_disjoint: assert property (@(posedge clk_i) disable iff (rst_i)
    pa_q |-> !pb_q) else $error("both channels pulsed at once");

endmodule

/* sim/lcoc_switch_model.sv */
`timescale 1ns/100ps
// Operator switch in parallel with the machine contacts
module lcoc_switch_model (
  // Operator and contact state
  input wire logic press_i,
  input wire logic weld_i,
  // Loop seen by the receiver
  output logic loop_o
);
  // Loop closes while pressed; a welded contact pair holds it closed
  assign loop_o = press_i | weld_i;
endmodule

/* sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic beams = 1'b1;
  logic st_ok = 1'b1;
  logic fault = 1'b0;
  logic latch = 1'b1;
  logic press = 1'b0;
  logic weld = 1'b0;
  logic loop;
  logic out_a;
  logic out_b;
  logic run;
  logic lock;
  logic test;
  int n_errors = 0;
  int n_checks = 0;

  // Free-running 50 MHz clock
  always #10 clk_i = ~clk_i;

  lcoc_switch_model i_sw (.press_i(press), .weld_i(weld), .loop_o(loop));

  // Shortened counts keep the run brief
  lcoc_output_ctrl #(.PERIOD_CYC(200), .PULSE_CYC(10), .DEBOUNCE_CYC(4),
    .STUCK_CYC(50), .TEST_CYC(8)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .beams_clear_i(beams),
    .self_test_ok_i(st_ok), .internal_fault_i(fault), .latch_mode_i(latch),
    .switch_loop_i(loop), .safety_switch_output_a_o(out_a),
    .safety_switch_output_b_o(out_b), .run_o(run), .lockout_o(lock),
    .test_o(test));

  // Advance n edges, then settle off the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic do_reset();
    rst_i = 1'b1;
    step(8);
    rst_i = 1'b0;
    step(3);
  endtask

  // Close the loop n cycles, release, let the answer land
  task automatic actuate(input int n);
    press = 1'b1;
    step(n);
    press = 1'b0;
    step(5);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Latch mode start, short press, block, remote test
  task automatic t_latch();
    step(20);
    chk(out_a | out_b, 1'b0, "latch outputs on at power-up");
    actuate(2);
    chk(run, 1'b0, "short press accepted");
    actuate(8);
    chk(run & out_a & out_b, 1'b1, "reset did not start");
    beams = 1'b0;
    step(2);
    chk(out_a | out_b, 1'b0, "blocked beam left outputs on");
    beams = 1'b1;
    step(5);
    chk(out_a | out_b, 1'b0, "latch restarted alone");
    actuate(8);
    chk(run, 1'b1, "latch reset failed");
    actuate(8);
    chk(test & ~out_a & ~out_b, 1'b1, "no test when running");
    step(12);
    chk(run & out_a, 1'b1, "no return after test");
    $display("test latch done");
  endtask

  // Fault and stuck loop lockout and recovery
  task automatic t_fault();
    fault = 1'b1;
    step(2);
    chk(lock & ~out_a & ~out_b, 1'b1, "fault lockout");
    fault = 1'b0;
    step(1);
    fault = 1'b1;
    actuate(8);
    chk(lock, 1'b1, "reset honoured during fault");
    fault = 1'b0;
    actuate(8);
    chk(lock | run, 1'b0, "lockout reset");
    actuate(8);
    chk(run, 1'b1, "second reset after lockout");
    weld = 1'b1;
    step(60);
    chk(lock & ~out_a, 1'b1, "stuck loop lockout");
    weld = 1'b0;
    step(5);
    chk(lock, 1'b1, "stuck release taken as reset");
    $display("test fault done");
  endtask

  // Trip mode start, pulses, auto restart
  task automatic t_trip();
    int na;
    int nb;
    int nab;
    na = 0;
    nb = 0;
    nab = 0;
    latch = 1'b0;
    st_ok = 1'b0;
    do_reset();
    step(10);
    chk(out_a | out_b, 1'b0, "on before self-test");
    st_ok = 1'b1;
    step(3);
    chk(run & out_a & out_b, 1'b1, "trip start");
    for (int i = 0; i < 220; i++) begin
      na += int'(!out_a);
      nb += int'(!out_b);
      nab += int'(!out_a && !out_b);
      step(1);
    end
    chk(na == 10, 1'b1, "channel a pulse length");
    chk(nb == 10, 1'b1, "channel b pulse length");
    chk(nab == 0, 1'b1, "both channels off together");
    beams = 1'b0;
    step(2);
    chk(out_a | out_b, 1'b0, "trip block");
    beams = 1'b1;
    step(3);
    chk(run & out_a, 1'b1, "trip auto restart");
    $display("test trip done");
  endtask

  // Enable low freezes state; a block is only acted on once enabled
  task automatic t_ce();
    ce = 1'b0;
    beams = 1'b0;
    step(4);
    chk(run & out_a & out_b, 1'b1, "state moved with enable low");
    ce = 1'b1;
    step(2);
    chk(out_a | out_b, 1'b0, "block missed after enable");
    beams = 1'b1;
    step(3);
    chk(run & out_a & out_b, 1'b1, "restart after enable");
    $display("test enable done");
  endtask

  // Main sequence
  initial begin
    do_reset();
    t_latch();
    t_fault();
    t_trip();
    t_ce();
    end_sim();
  end

  // Watchdog, well past the expected span of the tests
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
endmodule
